// File: pkg/dsau_cfg.svh
// dsau_cfg.svh: address map, steps and vector ranges of the access unit.
// assumes a 16-bit byte-addressed data space and a 24-bit program counter.
`ifndef DSAU_CFG_SVH
`define DSAU_CFG_SVH

`define DSAU_SFR_LAST      16'h07ff
`define DSAU_RAM_BASE      16'h0800
`define DSAU_RAM_BYTES     30720
`define DSAU_XY_BOUNDARY   16'h4800
`define DSAU_WIN_BIT       15
`define DSAU_NEAR_W        13
`define DSAU_NEAR_PAD      3'h0
`define DSAU_STEP_BYTE     16'h0001
`define DSAU_STEP_WORD     16'h0002
`define DSAU_PC_STEP       24'h000002
`define DSAU_VEC_PRI_FIRST 24'h000004
`define DSAU_VEC_PRI_LAST  24'h0000ff
`define DSAU_VEC_ALT_FIRST 24'h000100
`define DSAU_VEC_ALT_LAST  24'h0001ff
`define DSAU_ZERO16        16'h0000
`define DSAU_ZERO8         8'h00

`endif

// File: pkg/dsau_pkg.sv
// dsau_pkg: types shared by the data space access unit and its leaves.
// assumes nothing beyond a SystemVerilog tool.
`default_nettype none

package dsau_pkg;

    // where an effective address lands
    typedef enum logic [1:0] {
        DSAU_RGN_SFR  = 2'b00,
        DSAU_RGN_RAM  = 2'b01,
        DSAU_RGN_WIN  = 2'b10,
        DSAU_RGN_NONE = 2'b11
    } dsau_region_e;

    // how the instruction carries its address
    typedef enum logic [1:0] {
        DSAU_AM_NEAR = 2'b00,
        DSAU_AM_DIR  = 2'b01,
        DSAU_AM_IND  = 2'b10
    } dsau_amode_e;

    typedef struct packed {
        logic        valid;
        logic        byte_op;
        dsau_amode_e amode;
        logic [15:0] field;
        logic [15:0] wreg_old;
    } dsau_rd_req_s;

    typedef struct packed {
        logic        valid;
        logic        byte_op;
        dsau_amode_e amode;
        logic [15:0] field;
        logic [15:0] data;
    } dsau_wr_req_s;

    typedef struct packed {
        logic        valid;
        logic        byte_op;
        logic        mod_en;
        logic        bitrev_en;
        logic        x_write;
        logic [15:0] ptr;
        logic [15:0] mod_start;
        logic [15:0] mod_end;
        logic [15:0] bitrev_mod;
    } dsau_ptr_req_s;

    typedef struct packed {
        logic        valid;
        logic        decrement;
        logic [23:0] pc;
    } dsau_prog_req_s;

    typedef struct packed {
        logic         valid;
        logic         byte_op;
        logic         lsb;
        dsau_region_e rgn;
        logic [15:0]  old;
    } dsau_stage_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
        logic [15:0] wreg;
    } dsau_rd_rsp_s;

    typedef struct packed {
        logic        we_lo;
        logic        we_hi;
        logic [15:0] addr;
        logic [15:0] data;
    } dsau_sfr_wr_s;

    typedef struct packed {
        logic        valid;
        logic        upper;
        logic [15:0] word;
        logic [23:0] pc_next;
        logic        vec_primary;
        logic        vec_alt;
    } dsau_prog_rsp_s;

    typedef struct packed {
        dsau_stage_s    x1;
        dsau_stage_s    y1;
        logic [15:0]    sfr_addr;
        logic [15:0]    win_addr;
        dsau_rd_rsp_s   x_rsp;
        dsau_rd_rsp_s   y_rsp;
        dsau_sfr_wr_s   sfr_wr;
        logic           trap;
        logic           ptr_valid;
        logic [15:0]    ptr_next;
        dsau_prog_rsp_s prog;
    } dsau_state_s;

endpackage : dsau_pkg

`default_nettype wire

// File: logic/dsau_region_decode.sv
// dsau_region_decode: sorts one effective address into its region.
// assumes the ram sits directly above the register area.
`default_nettype none
`include "dsau_cfg.svh"

module dsau_region_decode #(
    parameter int RAM_BYTES = `DSAU_RAM_BYTES
) (
    input  wire logic [15:0]          addr_in,
    output dsau_pkg::dsau_region_e    region_out
);
    localparam logic [16:0] RAM_END =
        17'(`DSAU_RAM_BASE) + 17'(RAM_BYTES);

    // top bit picks the program window before anything else
    always_comb begin
        if (addr_in[`DSAU_WIN_BIT]) begin
            region_out = dsau_pkg::DSAU_RGN_WIN;
        end else if (addr_in <= `DSAU_SFR_LAST) begin
            region_out = dsau_pkg::DSAU_RGN_SFR;
        end else if ({1'b0, addr_in} < RAM_END) begin
            region_out = dsau_pkg::DSAU_RGN_RAM;
        end else begin
            region_out = dsau_pkg::DSAU_RGN_NONE;
        end
    end
endmodule : dsau_region_decode

`default_nettype wire

// File: logic/dsau_word_ram.sv
// dsau_word_ram: data ram as two byte lanes with one shared word decode.
// assumes one write port and two read ports; read data are registered.
`default_nettype none

module dsau_word_ram #(
    parameter int WORDS = 15360,
    parameter int AW    = 14
) (
    input  wire logic          clk_sys_in,
    input  wire logic          reset_in,
    input  wire logic          we_lo_in,
    input  wire logic          we_hi_in,
    input  wire logic [AW-1:0] waddr_in,
    input  wire logic [15:0]   wdata_in,
    input  wire logic [AW-1:0] xaddr_in,
    input  wire logic [AW-1:0] yaddr_in,
    output logic      [15:0]   xdata_out,
    output logic      [15:0]   ydata_out
);
    logic [7:0] lane_lo [WORDS];
    logic [7:0] lane_hi [WORDS];

    // separate lane strobes, so a byte write leaves its partner intact
    always_ff @(posedge clk_sys_in) begin
        if (we_lo_in) begin
            lane_lo[waddr_in] <= wdata_in[7:0];
        end
        if (we_hi_in) begin
            lane_hi[waddr_in] <= wdata_in[15:8];
        end
    end

    // read before write when both hit one word in a cycle
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            xdata_out <= 16'h0000;
            ydata_out <= 16'h0000;
        end else begin
            xdata_out <= {lane_hi[xaddr_in], lane_lo[xaddr_in]};
            ydata_out <= {lane_hi[yaddr_in], lane_lo[yaddr_in]};
        end
    end
endmodule : dsau_word_ram

`default_nettype wire

// File: logic/dsau_access_unit.sv
// dsau_access_unit: data space decode, byte lanes, traps, pointer and
// program counter stepping for the core's address generation units.
// assumes register file answers within the cycle its address is shown.
//
// Overview of operation
// R1: effective addresses are 16 bits, each names one byte, 64 Kbytes.
// R2: top bit clear goes to memory, top bit set to program window.
// R3: up to 30 Kbytes implemented; reads outside return zero.
// R4: words stored low byte at even address, high byte at odd.
// R5: byte read fetches the word, picks by bit zero, returns low.
// R6: one word decode, two byte strobes; byte write touches its lane.
// R7: post-modify steps pointer by one for bytes, two for words.
// R8: misaligned word access traps; a misaligned write is suppressed.
// R9: byte load changes only the working register's low byte.
// R10: 0x0000 to 0x07FF are registers; unused ones read zero.
// R11: near area 0x0000 to 0x1FFF reached by 13-bit direct field.
// R12: whole space reached by 16-bit direct field or register pointer.
// R13: X and Y have own address units and data paths.
// R14: X has separate read and write buses; X read serves all.
// R15: Y read path used only by the dual-fetch instruction class.
// R16: modulo in X and Y; bit-reversed only for X writes.
// R17: all writes use combined space; X/Y boundary fixed.
// R18: program location is lower word even, upper word odd, top zero.
// R19: program addresses aligned to lower word, pc steps by two.
// R20: vector tables 0x000004-0x0000FF and 0x000100-0x0001FF.
// R21: address error trap is a one-cycle pulse.
`default_nettype none
`include "dsau_cfg.svh"

module dsau_access_unit #(
    parameter int             RAM_BYTES   = `DSAU_RAM_BYTES,
    parameter logic [15:0]    XY_BOUNDARY = `DSAU_XY_BOUNDARY
) (
    input  wire logic                     clk_sys_in,
    input  wire logic                     reset_in,
    input  wire dsau_pkg::dsau_rd_req_s   x_rd_in,
    input  wire dsau_pkg::dsau_rd_req_s   y_rd_in,
    input  wire logic                     dual_fetch_in,
    input  wire dsau_pkg::dsau_wr_req_s   wr_in,
    input  wire dsau_pkg::dsau_ptr_req_s  ptr_in,
    input  wire dsau_pkg::dsau_prog_req_s prog_in,
    input  wire logic [23:0]              prog_rdata_in,
    input  wire logic [15:0]              sfr_rdata_in,
    input  wire logic                     sfr_hit_in,
    input  wire logic [15:0]              win_rdata_in,
    output dsau_pkg::dsau_rd_rsp_s        x_rsp_out,
    output dsau_pkg::dsau_rd_rsp_s        y_rsp_out,
    output logic [15:0]                   sfr_addr_out,
    output logic [15:0]                   win_addr_out,
    output dsau_pkg::dsau_sfr_wr_s        sfr_wr_out,
    output logic                          addr_error_out,
    output logic                          ptr_valid_out,
    output logic [15:0]                   ptr_next_out,
    output dsau_pkg::dsau_prog_rsp_s      prog_out
);
    localparam int WORDS = RAM_BYTES / 2;
    localparam int AW    = $clog2(WORDS);
    localparam logic [14:0] BASE_WORD = 15'(`DSAU_RAM_BASE >> 1);

    dsau_pkg::dsau_state_s  state_reg;
    dsau_pkg::dsau_state_s  state_next;
    dsau_pkg::dsau_region_e x_rgn;
    dsau_pkg::dsau_region_e y_rgn;
    dsau_pkg::dsau_region_e w_rgn;
    logic [15:0]            x_ea;
    logic [15:0]            w_ea;
    logic [15:0]            y_ea;
    logic [15:0]            x_word;
    logic [15:0]            y_word;
    logic                   x_bad;
    logic                   y_bad;
    logic                   w_bad;
    logic                   y_take;
    logic                   ram_we_lo;
    logic                   ram_we_hi;
    logic [AW-1:0]          ram_waddr;
    logic [AW-1:0]          ram_xaddr;
    logic [AW-1:0]          ram_yaddr;

    // near form pads the 13-bit field; direct and pointer use all 16
    function automatic logic [15:0] form_ea(
        input dsau_pkg::dsau_amode_e am,
        input logic [15:0]           fld
    );
        if (am == dsau_pkg::DSAU_AM_NEAR) begin
            form_ea = {`DSAU_NEAR_PAD, fld[`DSAU_NEAR_W-1:0]}; // R11
        end else begin
            form_ea = fld; // R12
        end
    endfunction : form_ea

    function automatic logic [15:0] rev16(input logic [15:0] v);
        for (int i = 0; i < 16; i++) begin
            rev16[i] = v[15-i];
        end
    endfunction : rev16

    function automatic logic [AW-1:0] word_index(input logic [15:0] a);
        logic [14:0] off;
        off        = a[15:1] - BASE_WORD;
        word_index = off[AW-1:0];
    endfunction : word_index

    // effective addresses for both read units and the write unit
    assign x_ea   = form_ea(x_rd_in.amode, x_rd_in.field); // R1
    assign w_ea   = form_ea(wr_in.amode, wr_in.field); // R17
    assign y_ea   = y_rd_in.field; // R13
    assign y_take = y_rd_in.valid & dual_fetch_in; // R15

    // a word access with bit zero set is misaligned
    assign x_bad = x_rd_in.valid & ~x_rd_in.byte_op & x_ea[0]; // R8
    assign y_bad = y_take & ~y_rd_in.byte_op & y_ea[0]; // R8
    assign w_bad = wr_in.valid & ~wr_in.byte_op & w_ea[0]; // R8

    dsau_region_decode #(.RAM_BYTES(RAM_BYTES)) u_x_decode (
        .addr_in    (x_ea),
        .region_out (x_rgn)
    );

    dsau_region_decode #(.RAM_BYTES(RAM_BYTES)) u_y_decode (
        .addr_in    (y_ea),
        .region_out (y_rgn)
    );

    dsau_region_decode #(.RAM_BYTES(RAM_BYTES)) u_w_decode (
        .addr_in    (w_ea),
        .region_out (w_rgn)
    );

    // ram lane strobes; a faulting word write never reaches a lane
    always_comb begin
        ram_we_lo = 1'b0;
        ram_we_hi = 1'b0;
        if (wr_in.valid && !w_bad && w_rgn == dsau_pkg::DSAU_RGN_RAM) begin
            ram_we_lo = ~wr_in.byte_op | ~w_ea[0]; // R6
            ram_we_hi = ~wr_in.byte_op | w_ea[0]; // R6
        end
    end

    assign ram_waddr = word_index(w_ea);
    assign ram_xaddr = word_index(x_ea);
    assign ram_yaddr = word_index(y_ea);

    dsau_word_ram #(.WORDS(WORDS), .AW(AW)) u_ram (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .we_lo_in   (ram_we_lo),
        .we_hi_in   (ram_we_hi),
        .waddr_in   (ram_waddr),
        .wdata_in   (wr_in.data),
        .xaddr_in   (ram_xaddr),
        .yaddr_in   (ram_yaddr),
        .xdata_out  (x_word),
        .ydata_out  (y_word)
    );

    // next state: stage one decodes, stage two returns data
    always_comb begin
        logic [15:0] xw;
        logic [15:0] yw;
        logic [15:0] step;
        logic [15:0] sum;
        xw         = `DSAU_ZERO16;
        yw         = `DSAU_ZERO16;
        step       = `DSAU_ZERO16;
        sum        = `DSAU_ZERO16;
        state_next = state_reg;

        // stage one, X: a faulting read is forced to the empty region
        state_next.x1.valid   = x_rd_in.valid;
        state_next.x1.byte_op = x_rd_in.byte_op;
        state_next.x1.lsb     = x_ea[0];
        state_next.x1.old     = x_rd_in.wreg_old;
        state_next.x1.rgn     = x_bad ? dsau_pkg::DSAU_RGN_NONE : x_rgn;
        state_next.sfr_addr   = {x_ea[15:1], 1'b0};
        state_next.win_addr   = x_ea; // R2

        // stage one, Y: only ram above the fixed boundary is Y space
        state_next.y1.valid   = y_take; // R15
        state_next.y1.byte_op = y_rd_in.byte_op;
        state_next.y1.lsb     = y_ea[0];
        state_next.y1.old     = y_rd_in.wreg_old;
        if (y_bad || y_rgn != dsau_pkg::DSAU_RGN_RAM
                  || y_ea < XY_BOUNDARY) begin
            state_next.y1.rgn = dsau_pkg::DSAU_RGN_NONE; // R3
        end else begin
            state_next.y1.rgn = dsau_pkg::DSAU_RGN_RAM;
        end

        // stage two, X: pick the word source, unused spots read zero
        case (state_reg.x1.rgn)
            dsau_pkg::DSAU_RGN_RAM: begin
                xw = x_word;
            end
            dsau_pkg::DSAU_RGN_SFR: begin
                xw = sfr_hit_in ? sfr_rdata_in : `DSAU_ZERO16; // R10
            end
            dsau_pkg::DSAU_RGN_WIN: begin
                xw = win_rdata_in; // R2
            end
            default: begin
                xw = `DSAU_ZERO16; // R3
            end
        endcase
        yw = (state_reg.y1.rgn == dsau_pkg::DSAU_RGN_RAM) ?
             y_word : `DSAU_ZERO16;

        // byte reads land on the low byte; odd address is the high byte
        state_next.x_rsp.valid = state_reg.x1.valid; // R14
        if (state_reg.x1.byte_op) begin
            state_next.x_rsp.data = {`DSAU_ZERO8,
                state_reg.x1.lsb ? xw[15:8] : xw[7:0]}; // R4 R5
            state_next.x_rsp.wreg = {state_reg.x1.old[15:8],
                state_next.x_rsp.data[7:0]}; // R9
        end else begin
            state_next.x_rsp.data = xw;
            state_next.x_rsp.wreg = xw;
        end
        state_next.y_rsp.valid = state_reg.y1.valid; // R13
        if (state_reg.y1.byte_op) begin
            state_next.y_rsp.data = {`DSAU_ZERO8,
                state_reg.y1.lsb ? yw[15:8] : yw[7:0]}; // R5
            state_next.y_rsp.wreg = {state_reg.y1.old[15:8],
                state_next.y_rsp.data[7:0]}; // R9
        end else begin
            state_next.y_rsp.data = yw;
            state_next.y_rsp.wreg = yw;
        end

        // register writes go out on their own lane strobes
        state_next.sfr_wr.addr  = {w_ea[15:1], 1'b0};
        state_next.sfr_wr.data  = wr_in.data;
        state_next.sfr_wr.we_lo = 1'b0;
        state_next.sfr_wr.we_hi = 1'b0;
        if (wr_in.valid && !w_bad && w_rgn == dsau_pkg::DSAU_RGN_SFR) begin
            state_next.sfr_wr.we_lo = ~wr_in.byte_op | ~w_ea[0]; // R6
            state_next.sfr_wr.we_hi = ~wr_in.byte_op | w_ea[0]; // R6
        end

        // one pulse per faulting cycle, however many units fault
        state_next.trap = x_bad | y_bad | w_bad; // R21

        // pointer post-modify: step, then modulo wrap or reversed carry
        step = ptr_in.byte_op ? `DSAU_STEP_BYTE : `DSAU_STEP_WORD; // R7
        sum  = ptr_in.ptr + step;
        if (ptr_in.bitrev_en && ptr_in.x_write) begin
            sum = rev16(rev16(ptr_in.ptr) + rev16(ptr_in.bitrev_mod)); // R16
        end else if (ptr_in.mod_en && ptr_in.ptr == ptr_in.mod_end) begin
            sum = ptr_in.mod_start; // R16
        end
        state_next.ptr_valid = ptr_in.valid;
        state_next.ptr_next  = sum;

        // program side: word select, pc step, vector table flags
        state_next.prog.valid = prog_in.valid;
        state_next.prog.upper = prog_in.pc[0]; // R18
        state_next.prog.word  = prog_in.pc[0] ?
            {`DSAU_ZERO8, prog_rdata_in[23:16]} : prog_rdata_in[15:0];
        state_next.prog.pc_next = prog_in.decrement ?
            prog_in.pc - `DSAU_PC_STEP : prog_in.pc + `DSAU_PC_STEP; // R19
        state_next.prog.vec_primary =
            prog_in.pc >= `DSAU_VEC_PRI_FIRST &&
            prog_in.pc <= `DSAU_VEC_PRI_LAST; // R20
        state_next.prog.vec_alt =
            prog_in.pc >= `DSAU_VEC_ALT_FIRST &&
            prog_in.pc <= `DSAU_VEC_ALT_LAST; // R20
    end

    // all control state clears to zero, so outputs idle low
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign x_rsp_out      = state_reg.x_rsp;
    assign y_rsp_out      = state_reg.y_rsp;
    assign sfr_addr_out   = state_reg.sfr_addr;
    assign win_addr_out   = state_reg.win_addr;
    assign sfr_wr_out     = state_reg.sfr_wr;
    assign addr_error_out = state_reg.trap;
    assign ptr_valid_out  = state_reg.ptr_valid;
    assign ptr_next_out   = state_reg.ptr_next;
    assign prog_out       = state_reg.prog;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    sequence s_x_misaligned;
        x_rd_in.valid && !x_rd_in.byte_op && x_ea[0];
    endsequence

    sequence s_w_misaligned;
        wr_in.valid && !wr_in.byte_op && w_ea[0];
    endsequence

    sequence s_x_window_read;
        x_rd_in.valid && !x_rd_in.byte_op && x_ea[15] && !x_ea[0];
    endsequence

    chk_trap_on_misread: assert property ( // R8
        s_x_misaligned |=> addr_error_out ##1 !$past(x_bad) || addr_error_out)
        else $error("misaligned read gave no trap");

    chk_write_blocked: assert property ( // R8
        s_w_misaligned |-> !ram_we_lo && !ram_we_hi
            ##1 addr_error_out && !sfr_wr_out.we_lo && !sfr_wr_out.we_hi)
        else $error("misaligned write reached a lane");

    chk_trap_pulse: assert property ( // R21
        addr_error_out |-> $past(x_bad) || $past(y_bad) || $past(w_bad))
        else $error("trap pulse without a fault");

    chk_byte_lane_lo: assert property ( // R6
        wr_in.valid && wr_in.byte_op && !w_ea[0]
            && w_rgn == dsau_pkg::DSAU_RGN_RAM |-> ram_we_lo && !ram_we_hi)
        else $error("even byte write hit the wrong lane");

    chk_window_path: assert property ( // R2
        s_x_window_read ##1 1'b1 |=> x_rsp_out.valid
            && x_rsp_out.data == $past(win_rdata_in))
        else $error("window read did not return window data");

    chk_byte_merge: assert property ( // R9
        x_rd_in.valid && x_rd_in.byte_op |-> ##2 x_rsp_out.valid
            && x_rsp_out.wreg[15:8] == $past(x_rd_in.wreg_old[15:8], 2)
            && x_rsp_out.data[15:8] == `DSAU_ZERO8)
        else $error("byte load disturbed the high byte");

    chk_y_gated: assert property ( // R15
        y_rd_in.valid && !dual_fetch_in |-> ##2 !y_rsp_out.valid)
        else $error("Y path used outside dual fetch");

    chk_y_below_boundary: assert property ( // R3
        y_take && y_ea < XY_BOUNDARY |-> ##2 y_rsp_out.data == `DSAU_ZERO16)
        else $error("Y read below boundary was not zero");

    chk_ptr_word_step: assert property ( // R7
        ptr_in.valid && !ptr_in.byte_op && !ptr_in.mod_en
            && !ptr_in.bitrev_en |=> ptr_valid_out
            && ptr_next_out == $past(ptr_in.ptr) + `DSAU_STEP_WORD)
        else $error("word pointer step is not two");

    chk_pc_step: assert property ( // R19
        prog_in.valid && !prog_in.decrement |=> prog_out.valid
            && prog_out.pc_next == $past(prog_in.pc) + `DSAU_PC_STEP)
        else $error("program counter step is not two");

    chk_upper_word: assert property ( // R18
        prog_out.valid && prog_out.upper |-> prog_out.word[15:8] == `DSAU_ZERO8)
        else $error("upper word top byte not zero");
endmodule : dsau_access_unit

`default_nettype wire

// File: testbench/dsau_core_model.sv
// dsau_core_model: register file, window and program memory stand-in.
// assumes the unit wants answers in the cycle its address is shown.
`default_nettype none

module dsau_core_model (
    input  wire logic [15:0] sfr_addr_in,
    input  wire logic [15:0] win_addr_in,
    input  wire logic [23:0] pc_in,
    output logic      [15:0] sfr_rdata_out,
    output logic             sfr_hit_out,
    output logic      [15:0] win_rdata_out,
    output logic      [23:0] prog_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // one live register; a miss drives junk the unit must zero
    assign sfr_hit_out    = (sfr_addr_in == 16'h0000);
    assign sfr_rdata_out  = sfr_hit_out ? 16'h1234 : 16'hedcb;
    // window data derived from the address, so any mixup shows
    assign win_rdata_out  = ~win_addr_in;
    assign prog_rdata_out = {8'h3c, pc_in[15:0]};
endmodule : dsau_core_model

`default_nettype wire

// File: testbench/dsau_access_unit_tb.sv
// dsau_access_unit_tb: directed scenarios for the data space access unit.
// assumes the core model answers register and window reads at once.
`default_nettype none

module dsau_access_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam dsau_pkg::dsau_amode_e am_ind  = dsau_pkg::DSAU_AM_IND;
    localparam dsau_pkg::dsau_amode_e am_dir  = dsau_pkg::DSAU_AM_DIR;
    localparam dsau_pkg::dsau_amode_e am_near = dsau_pkg::DSAU_AM_NEAR;
    logic                     clk_sys_in = 1'b0;
    logic                     reset_in   = 1'b1;
    logic                     dual       = 1'b0;
    logic                     tr;
    dsau_pkg::dsau_rd_req_s   x_rd = '0;
    dsau_pkg::dsau_rd_req_s   y_rd = '0;
    dsau_pkg::dsau_wr_req_s   wr   = '0;
    dsau_pkg::dsau_ptr_req_s  pr   = '0;
    dsau_pkg::dsau_prog_req_s pg   = '0;
    dsau_pkg::dsau_rd_rsp_s   xr, yr;
    dsau_pkg::dsau_sfr_wr_s   sw;
    dsau_pkg::dsau_prog_rsp_s po;
    logic [15:0]              sfr_a, win_a, sfr_d, win_d, pn;
    logic [23:0]              prog_d;
    logic                     hit, aerr, pv;
    int                       n_fail  = 0;
    int                       n_tests = 0;
    int                       cyc     = 0;

    dsau_access_unit dut (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .x_rd_in(x_rd),
        .y_rd_in(y_rd), .dual_fetch_in(dual), .wr_in(wr), .ptr_in(pr),
        .prog_in(pg), .prog_rdata_in(prog_d), .sfr_rdata_in(sfr_d),
        .sfr_hit_in(hit), .win_rdata_in(win_d), .x_rsp_out(xr),
        .y_rsp_out(yr), .sfr_addr_out(sfr_a), .win_addr_out(win_a),
        .sfr_wr_out(sw), .addr_error_out(aerr), .ptr_valid_out(pv),
        .ptr_next_out(pn), .prog_out(po));
    dsau_core_model core (
        .sfr_addr_in(sfr_a), .win_addr_in(win_a), .pc_in(pg.pc),
        .sfr_rdata_out(sfr_d), .sfr_hit_out(hit), .win_rdata_out(win_d),
        .prog_rdata_out(prog_d));

    always #5 clk_sys_in = ~clk_sys_in;
    // hang guard: scenarios need well under a hundred cycles
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic cmpv(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpv

    task automatic cmpf(input logic got, input logic exp);
        cmpv({15'h0000, got}, {15'h0000, exp});
    endtask : cmpf

    // one x read; trap sampled in the cycle after, answer one later
    task automatic rd(input logic b, input dsau_pkg::dsau_amode_e m,
                      input logic [15:0] a, input logic [15:0] w);
        @(posedge clk_sys_in);
        x_rd <= '{1'b1, b, m, a, w};
        @(posedge clk_sys_in);
        x_rd.valid <= 1'b0;
        @(negedge clk_sys_in);
        tr = aerr;
        @(negedge clk_sys_in);
        cmpf(xr.valid, 1'b1);
    endtask : rd

    task automatic wt(input logic b, input logic [15:0] a,
                      input logic [15:0] d);
        @(posedge clk_sys_in);
        wr <= '{1'b1, b, am_dir, a, d};
        @(posedge clk_sys_in);
        wr.valid <= 1'b0;
        @(negedge clk_sys_in);
        tr = aerr;
    endtask : wt

    task automatic t_word();
        wt(1'b0, 16'h0802, 16'hbeef);
        cmpf(tr, 1'b0);
        rd(1'b0, am_ind, 16'h0802, 16'h1111);
        cmpv(xr.data, 16'hbeef);
        cmpv(xr.wreg, 16'hbeef);
        rd(1'b1, am_ind, 16'h0803, 16'h7700);
        cmpv(xr.data, 16'h00be);
        cmpv(xr.wreg, 16'h77be);
        wt(1'b1, 16'h0803, 16'h5a00);
        rd(1'b0, am_near, 16'he802, 16'h0000);
        cmpv(xr.data, 16'h5aef);
        $display("test word done");
    endtask : t_word

    task automatic t_trap();
        wt(1'b0, 16'h0804, 16'h0000);
        wt(1'b0, 16'h0805, 16'h1234);
        cmpf(tr, 1'b1);
        @(negedge clk_sys_in);
        cmpf(aerr, 1'b0);
        rd(1'b0, am_ind, 16'h0804, 16'h0000);
        cmpv(xr.data, 16'h0000);
        rd(1'b0, am_ind, 16'h0803, 16'h0000);
        cmpf(tr, 1'b1);
        cmpv(xr.data, 16'h0000);
        $display("test trap done");
    endtask : t_trap

    task automatic t_sfr();
        wt(1'b1, 16'h0001, 16'h5500);
        cmpf(sw.we_hi, 1'b1);
        cmpf(sw.we_lo, 1'b0);
        cmpv(sw.addr, 16'h0000);
        cmpv(sw.data, 16'h5500);
        rd(1'b0, am_ind, 16'h0000, 16'h0000);
        cmpv(xr.data, 16'h1234);
        rd(1'b0, am_dir, 16'h07fe, 16'h0000);
        cmpv(xr.data, 16'h0000);
        rd(1'b0, am_dir, 16'h8004, 16'h0000);
        cmpv(xr.data, 16'h7ffb);
        $display("test sfr done");
    endtask : t_sfr

    // y answers only for the dual-fetch class
    task automatic t_dual();
        wt(1'b0, 16'h4800, 16'hc0de);
        for (int i = 2; i >= 0; i--) begin
            @(posedge clk_sys_in);
            y_rd <= '{1'b1, 1'b0, am_ind, 16'h47fe + 16'(i & 2), 16'h0000};
            dual <= i != 0;
            @(posedge clk_sys_in);
            y_rd.valid <= 1'b0;
            @(posedge clk_sys_in);
            @(negedge clk_sys_in);
            cmpf(yr.valid, i != 0);
            if (i != 0) cmpv(yr.data, i == 2 ? 16'hc0de : 16'h0000);
        end
        $display("test dual done");
    endtask : t_dual

    task automatic t_ptr();
        logic [15:0] want [4] = '{16'h1001, 16'h1002, 16'h0c00, 16'h0800};
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys_in);
            pr <= '{1'b1, i == 0, i == 2, i == 3, i == 3, 16'h1000,
                    16'h0c00, 16'h1000, 16'h1000};
            @(posedge clk_sys_in);
            pr.valid <= 1'b0;
            @(negedge clk_sys_in);
            cmpf(pv, 1'b1);
            cmpv(pn, want[i]);
        end
        $display("test ptr done");
    endtask : t_ptr

    // back to back: lower word up, then upper word stepping down
    task automatic t_prog();
        @(posedge clk_sys_in);
        pg <= '{1'b1, 1'b0, 24'h000100};
        @(posedge clk_sys_in);
        pg <= '{1'b1, 1'b1, 24'h000005};
        @(negedge clk_sys_in);
        cmpf(po.vec_alt, 1'b1);
        cmpf(po.vec_primary, 1'b0);
        cmpv(po.pc_next[15:0], 16'h0102);
        cmpv(po.word, 16'h0100);
        @(posedge clk_sys_in);
        pg.valid <= 1'b0;
        @(negedge clk_sys_in);
        cmpf(po.vec_primary, 1'b1);
        cmpf(po.upper, 1'b1);
        cmpv(po.word, 16'h003c);
        cmpv(po.pc_next[15:0], 16'h0003);
        $display("test prog done");
    endtask : t_prog

    task automatic print_verdict();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (5) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        @(negedge clk_sys_in);
        cmpf(aerr, 1'b0);
        t_word();
        t_trap();
        t_sfr();
        t_dual();
        t_ptr();
        t_prog();
        print_verdict();
    end
endmodule : dsau_access_unit_tb

`default_nettype wire
